// >>> src/tmc_twi_slave.sv
// Two-wire bus slave with an auto-incrementing byte pointer.
// Assumes scl and sda are pin levels; both are synchronised here.
`timescale 1ns/1ps
`default_nettype none
module tmc_twi_slave (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe,
  output logic [7:0] ptr,
  input wire logic [7:0] rd_data,
  output logic wr_en,
  output logic [7:0] wr_data,
  output logic busy
);

  logic [2:0] scl_s;
  logic [2:0] sda_s;
  tmc_pkg::tmc_twi_state_t state, next_state;
  logic [7:0] shreg, next_shreg;
  logic [3:0] bitn, next_bitn;
  logic first, next_first;
  logic mack, next_mack;
  logic next_sda_oe;
  logic [7:0] next_ptr;
  logic next_wr_en;
  logic [7:0] next_wr_data;
  logic scl_rise, scl_fall, start_c, stop_c;

  // Stages 0 and 1 synchronise; edges are found between stages 1 and 2.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
    end else begin
      scl_s <= {scl_s[1:0], scl_in};
      sda_s <= {sda_s[1:0], sda_in};
    end
  end

  assign scl_rise = scl_s[1] && !scl_s[2];
  assign scl_fall = !scl_s[1] && scl_s[2];
  assign start_c = scl_s[1] && scl_s[2] && !sda_s[1] && sda_s[2];
  assign stop_c = scl_s[1] && scl_s[2] && sda_s[1] && !sda_s[2];

  // Data is sampled on clock rise and changed on clock fall.
  always_comb begin
    next_state = state;
    next_shreg = shreg;
    next_bitn = bitn;
    next_first = first;
    next_mack = mack;
    next_sda_oe = sda_oe;
    next_ptr = ptr;
    next_wr_en = 1'b0;
    next_wr_data = wr_data;
    if (start_c) begin
      next_state = tmc_pkg::TMC_ADDR;
      next_bitn = '0;
      next_sda_oe = 1'b0;
    end else if (stop_c) begin
      next_state = tmc_pkg::TMC_IDLE;
      next_sda_oe = 1'b0;
    end else if (scl_rise) begin
      case (state)
        tmc_pkg::TMC_ADDR, tmc_pkg::TMC_WRITE: begin
          next_shreg = {shreg[6:0], sda_s[1]};
          next_bitn = bitn + 1'b1;
        end
        tmc_pkg::TMC_READ_ACK: next_mack = !sda_s[1];
        default: next_mack = mack;
      endcase
    end else if (scl_fall) begin
      case (state)
        tmc_pkg::TMC_ADDR: begin
          if (bitn == 4'h8) begin
            if (shreg[7:1] == tmc_pkg::DIAG_DEV_ADDR) begin
              next_state = tmc_pkg::TMC_ACK_ADDR;
              next_sda_oe = 1'b1;
            end else begin
              next_state = tmc_pkg::TMC_IDLE;
            end
          end
        end
        tmc_pkg::TMC_ACK_ADDR: begin
          next_bitn = '0;
          next_first = 1'b1;
          if (shreg[0]) begin
            next_state = tmc_pkg::TMC_READ;
            next_shreg = {rd_data[6:0], 1'b0};
            next_sda_oe = !rd_data[7];
            next_ptr = ptr + 1'b1;
            next_bitn = 4'h1;
          end else begin
            next_state = tmc_pkg::TMC_WRITE;
            next_sda_oe = 1'b0;
          end
        end
        tmc_pkg::TMC_WRITE: begin
          if (bitn == 4'h8) begin
            next_state = tmc_pkg::TMC_ACK_WRITE;
            next_sda_oe = 1'b1;
            if (first) begin
              next_ptr = shreg;
            end else begin
              next_wr_en = 1'b1;
              next_wr_data = shreg;
            end
          end
        end
        tmc_pkg::TMC_ACK_WRITE: begin
          next_state = tmc_pkg::TMC_WRITE;
          next_sda_oe = 1'b0;
          next_bitn = '0;
          // The pointer moves after the write pulse has used it.
          if (!first) begin
            next_ptr = ptr + 1'b1;
          end
          // The pointer byte itself must not advance the pointer.
          next_first = 1'b0;
        end
        tmc_pkg::TMC_READ: begin
          if (bitn == 4'h8) begin
            next_state = tmc_pkg::TMC_READ_ACK;
            next_sda_oe = 1'b0;
          end else begin
            next_sda_oe = !shreg[7];
            next_shreg = {shreg[6:0], 1'b0};
            next_bitn = bitn + 1'b1;
          end
        end
        tmc_pkg::TMC_READ_ACK: begin
          if (mack) begin
            next_state = tmc_pkg::TMC_READ;
            next_shreg = {rd_data[6:0], 1'b0};
            next_sda_oe = !rd_data[7];
            next_ptr = ptr + 1'b1;
            next_bitn = 4'h1;
          end else begin
            next_state = tmc_pkg::TMC_IDLE;
          end
        end
        default: next_state = tmc_pkg::TMC_IDLE;
      endcase
    end
  end

  // Slave state registers; the bus line is released at reset.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= tmc_pkg::TMC_IDLE;
      shreg <= '0;
      bitn <= '0;
      first <= 1'b0;
      mack <= 1'b0;
      sda_oe <= 1'b0;
      ptr <= '0;
      wr_en <= 1'b0;
      wr_data <= '0;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      shreg <= next_shreg;
      bitn <= next_bitn;
      first <= next_first;
      mack <= next_mack;
      sda_oe <= next_sda_oe;
      ptr <= next_ptr;
      wr_en <= next_wr_en;
      wr_data <= next_wr_data;
      busy <= (next_state != tmc_pkg::TMC_IDLE);
    end
  end

endmodule
`default_nettype wire

// >>> src/tmc_pkg.sv
// Shared constants of the transceiver management control block.
// Assumes a 250 MHz core clock and the host acting as two-wire bus master.
//
// Function
// - Transmitter turns off within 10 us of disable, back on within 1 ms.
// - Disable high or left open means transmitter off; low means on.
// - Init, clearing the fault indication too, ends within 300 ms.
// - Fault output rises within 100 us of a laser fault.
// - Fault output is 1 on laser fault and 0 in normal operation.
// - Loss-of-signal output rises within 100 us of light loss.
// - Loss-of-signal output falls within 100 us of light returning.
// - Loss-of-signal output is 1 without light and 0 when receiving.
// - Presence pin is held at ground permanently.
// - Bus address 1010001X is answered with a 256-byte diagnostic page.
// - Page holds thresholds, calibration, live, vendor and user bytes.
// - Five live monitor values are reported through the page.
// - Monitor values arrive already calibrated and are served unchanged.
`default_nettype none
package tmc_pkg;

  // Core clock rate in MHz.
  localparam int CLK_MHZ = 250;

  // Timing figures in their own units.
  localparam int T_OFF_US = 10;
  localparam int T_ON_MS = 1;
  localparam int T_INIT_MS = 300;
  localparam int T_FAULT_US = 100;
  localparam int T_RESET_US = 10;
  localparam int T_LOS_US = 100;

  // Derived cycle counts; the longest, T_INIT_CYC, is the default of the top parameter.
  localparam int T_OFF_CYC = T_OFF_US * CLK_MHZ;
  localparam int T_ON_CYC = T_ON_MS * 1000 * CLK_MHZ;
  localparam int T_INIT_CYC = T_INIT_MS * 1000 * CLK_MHZ;
  localparam int T_FAULT_CYC = T_FAULT_US * CLK_MHZ;
  localparam int T_RESET_CYC = T_RESET_US * CLK_MHZ;
  localparam int T_LOS_CYC = T_LOS_US * CLK_MHZ;
  localparam int INIT_CNT_W = 27;
  localparam int RESET_CNT_W = 12;

  // Two-wire device address, upper seven bits.
  localparam logic [6:0] DIAG_DEV_ADDR = 7'h51;

  // Diagnostic page layout, byte offsets.
  localparam logic [7:0] THRESH_FIRST = 8'h00;
  localparam logic [7:0] CAL_FIRST = 8'h38;
  localparam logic [7:0] LIVE_FIRST = 8'h60;
  localparam logic [7:0] TEMP_OFS = 8'h60;
  localparam logic [7:0] VCC_OFS = 8'h62;
  localparam logic [7:0] BIAS_OFS = 8'h64;
  localparam logic [7:0] TXPWR_OFS = 8'h66;
  localparam logic [7:0] RXPWR_OFS = 8'h68;
  localparam logic [7:0] STATUS_OFS = 8'h6e;
  localparam logic [7:0] VENDOR_A_FIRST = 8'h78;
  localparam logic [7:0] USER_FIRST = 8'h80;
  localparam logic [7:0] USER_LAST = 8'hf7;

  // Status byte field positions.
  localparam int ST_DISABLE_BIT = 7;
  localparam int ST_FAULT_BIT = 2;
  localparam int ST_LOS_BIT = 1;

  // Reset value of page bytes.
  localparam logic [7:0] PAGE_RESET = 8'h00;

  // Two-wire slave states.
  typedef enum logic [2:0] {
    TMC_IDLE,
    TMC_ADDR,
    TMC_ACK_ADDR,
    TMC_WRITE,
    TMC_ACK_WRITE,
    TMC_READ,
    TMC_READ_ACK
  } tmc_twi_state_t;

endpackage
`default_nettype wire

// >>> src/tmc_laser_ctl.sv
// Transmitter enable, power-on initialization and latched laser fault.
// Assumes disable and fault inputs are already synchronised to clk.
`timescale 1ns/1ps
`default_nettype none
module tmc_laser_ctl #(
  parameter int INIT_CYCLES = tmc_pkg::T_INIT_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tx_disable,
  input wire logic fault_cond,
  output logic tx_enable,
  output logic tx_fault,
  output logic init_done
);

  logic [tmc_pkg::INIT_CNT_W-1:0] init_cnt;
  logic [tmc_pkg::RESET_CNT_W-1:0] hold_cnt;
  logic hold_ok;
  logic [tmc_pkg::INIT_CNT_W-1:0] next_init_cnt;
  logic [tmc_pkg::RESET_CNT_W-1:0] next_hold_cnt;
  logic next_hold_ok;
  logic next_tx_enable;
  logic next_tx_fault;
  logic next_init_done;

  // The hold counter saturates, so a long disable still counts as one reset.
  always_comb begin
    next_init_cnt = init_cnt;
    next_init_done = init_done;
    next_hold_cnt = hold_cnt;
    next_hold_ok = hold_ok;
    next_tx_fault = tx_fault;
    if (!init_done) begin
      if (init_cnt == tmc_pkg::INIT_CNT_W'(INIT_CYCLES - 1)) begin
        next_init_done = 1'b1;
      end else begin
        next_init_cnt = init_cnt + 1'b1;
      end
    end
    if (tx_disable) begin
      if (hold_cnt == tmc_pkg::RESET_CNT_W'(tmc_pkg::T_RESET_CYC - 1)) begin
        next_hold_ok = 1'b1;
      end else begin
        next_hold_cnt = hold_cnt + 1'b1;
      end
    end else begin
      next_hold_cnt = '0;
      next_hold_ok = 1'b0;
      if (hold_ok) begin
        next_tx_fault = 1'b0;
      end
    end
    // A fault seen in the clearing cycle wins, so a lasting fault re-asserts.
    if (init_done && fault_cond) begin
      next_tx_fault = 1'b1;
    end
    // Light is cut in the very next cycle, well within the off and on limits.
    next_tx_enable = next_init_done && !tx_disable &&
      !next_tx_fault;
  end

  // Fault indication is held clear through initialization.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      init_cnt <= '0;
      init_done <= 1'b0;
      hold_cnt <= '0;
      hold_ok <= 1'b0;
      tx_fault <= 1'b0;
      tx_enable <= 1'b0;
    end else begin
      init_cnt <= next_init_cnt;
      init_done <= next_init_done;
      hold_cnt <= next_hold_cnt;
      hold_ok <= next_hold_ok;
      tx_fault <= next_tx_fault;
      tx_enable <= next_tx_enable;
    end
  end

endmodule
`default_nettype wire

// >>> src/tmc_top.sv
// Management control of a pluggable optical transceiver.
// Assumes pin inputs are asynchronous and monitor words come from clk logic.
`timescale 1ns/1ps
`default_nettype none
module tmc_top #(
  parameter int INIT_CYCLES = tmc_pkg::T_INIT_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tx_disable_pin,
  input wire logic laser_fault_raw,
  input wire logic rx_light_lost_raw,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic tx_enable,
  output logic tx_fault,
  output logic rx_los,
  output logic present_gnd,
  input wire logic [15:0] mon_temp,
  input wire logic [15:0] mon_vcc,
  input wire logic [15:0] mon_bias,
  input wire logic [15:0] mon_tx_power,
  input wire logic [15:0] mon_rx_power
);

  logic [1:0] dis_s, flt_s, los_s;
  logic [7:0] ptr;
  logic [7:0] rd_data;
  logic wr_en;
  logic [7:0] wr_data;
  logic busy;
  logic init_done;
  logic [7:0] page [0:255];
  logic [79:0] live, next_live;
  logic next_rx_los;

  // True for the bytes that the host may overwrite.
  function automatic logic user_byte(input logic [7:0] a);
    user_byte = (a >= tmc_pkg::USER_FIRST) && (a <= tmc_pkg::USER_LAST);
  endfunction

  // Two-stage synchronisers; an open disable pin reads high via pull-up.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dis_s <= 2'h3;
      flt_s <= 2'h0;
      los_s <= 2'h3;
    end else begin
      dis_s <= {dis_s[0], tx_disable_pin};
      flt_s <= {flt_s[0], laser_fault_raw};
      los_s <= {los_s[0], rx_light_lost_raw};
    end
  end

  tmc_laser_ctl #(
    .INIT_CYCLES(INIT_CYCLES)
  ) u_laser (
    .clk(clk),
    .rst_n(rst_n),
    .tx_disable(dis_s[1]),
    .fault_cond(flt_s[1]),
    .tx_enable(tx_enable),
    .tx_fault(tx_fault),
    .init_done(init_done)
  );

  tmc_twi_slave u_twi (
    .clk(clk),
    .rst_n(rst_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_oe(sda_oe),
    .ptr(ptr),
    .rd_data(rd_data),
    .wr_en(wr_en),
    .wr_data(wr_data),
    .busy(busy)
  );

  // Monitor words are frozen during a transfer so a read pair stays coherent.
  always_comb begin
    next_live = live;
    if (!busy) begin
      next_live = {mon_temp, mon_vcc, mon_bias, mon_tx_power,
        mon_rx_power};
    end
    // Light loss and return are both passed on three cycles after the pin.
    next_rx_los = los_s[1];
  end

  // Live snapshot, loss output and the grounded presence line.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      live <= '0;
      rx_los <= 1'b1;
      present_gnd <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      live <= next_live;
      rx_los <= next_rx_los;
      present_gnd <= 1'b0;
      sda_out <= 1'b0;
    end
  end

  // Page storage; only the user region accepts host writes.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 256; i++) begin
        page[i] <= tmc_pkg::PAGE_RESET;
      end
    end else if (wr_en && user_byte(ptr)) begin
      page[ptr] <= wr_data;
    end
  end

  // Read mux over the page regions.
  always_comb begin
    rd_data = page[ptr];
    case (ptr)
      tmc_pkg::TEMP_OFS: rd_data = live[79:72];
      tmc_pkg::TEMP_OFS + 8'h01: rd_data = live[71:64];
      tmc_pkg::VCC_OFS: rd_data = live[63:56];
      tmc_pkg::VCC_OFS + 8'h01: rd_data = live[55:48];
      tmc_pkg::BIAS_OFS: rd_data = live[47:40];
      tmc_pkg::BIAS_OFS + 8'h01: rd_data = live[39:32];
      tmc_pkg::TXPWR_OFS: rd_data = live[31:24];
      tmc_pkg::TXPWR_OFS + 8'h01: rd_data = live[23:16];
      tmc_pkg::RXPWR_OFS: rd_data = live[15:8];
      tmc_pkg::RXPWR_OFS + 8'h01: rd_data = live[7:0];
      tmc_pkg::STATUS_OFS: begin
        rd_data = 8'h00;
        rd_data[tmc_pkg::ST_DISABLE_BIT] = dis_s[1];
        rd_data[tmc_pkg::ST_FAULT_BIT] = tx_fault;
        rd_data[tmc_pkg::ST_LOS_BIT] = rx_los;
        rd_data[0] = !init_done;
      end
      default: rd_data = page[ptr];
    endcase
  end

endmodule
`default_nettype wire

// >>> sim/tmc_top_monitor.sv
// Port checker for the transceiver management block.
// Assumes it is bound into tmc_top and clk is the only clock.
`timescale 1ns/1ps
`default_nettype none
module tmc_top_monitor #(
  parameter int INIT_CYCLES = tmc_pkg::T_INIT_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tx_disable_pin,
  input wire logic laser_fault_raw,
  input wire logic rx_light_lost_raw,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic tx_enable,
  input wire logic tx_fault,
  input wire logic rx_los,
  input wire logic present_gnd
);
  int up_cnt;
  logic warm;
  logic [3:0] dis_age;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Time since reset release, and since the disable pin was last high.
  always_ff @(posedge clk) begin
    up_cnt <= !rst_n ? 0 : up_cnt + int'(up_cnt < INIT_CYCLES + 8);
    dis_age <= tx_disable_pin ? 4'h0 : dis_age + {3'h0, dis_age != 4'hf};
  end
  // Margin past init so the enable path is surely armed.
  assign warm = up_cnt >= INIT_CYCLES + 8;

  chk_init_dark:
    assert property (up_cnt < INIT_CYCLES - 1 |-> !tx_enable)
    else $error("transmitter on during init");
  chk_off_fast:
    assert property (tx_disable_pin [*4] |-> !tx_enable)
    else $error("transmitter not off");
  chk_on_time:
    assert property ($fell(tx_disable_pin) && warm && !tx_fault &&
      !laser_fault_raw |-> ##[1:4] tx_enable)
    else $error("transmitter not back on");
  chk_fault_set:
    assert property ((laser_fault_raw && warm) [*4] |-> tx_fault)
    else $error("fault not raised");
  chk_fault_latch:
    assert property ($fell(tx_fault) |-> dis_age < 4'h8)
    else $error("fault cleared without disable pulse");
  chk_los_set:
    assert property (rx_light_lost_raw [*4] |-> rx_los)
    else $error("loss of signal not raised");
  // The edge of reset release does not feed the loss synchroniser yet.
  chk_los_clear:
    assert property ((up_cnt != 0) ##0 !rx_light_lost_raw [*4] |-> !rx_los)
    else $error("loss of signal not cleared");
  chk_present_tied:
    assert property (present_gnd == 1'b0)
    else $error("presence pin not grounded");
  chk_sda_pull:
    assert property (sda_out == 1'b0)
    else $error("data wire driven high");
  chk_sda_scl_low:
    assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data wire moved while bus clock high");

  cover property ($rose(tx_fault));
  cover property ($rose(rx_los));
  cover property ($rose(sda_oe));
endmodule

bind tmc_top tmc_top_monitor #(.INIT_CYCLES(INIT_CYCLES)) tmc_top_monitor_i (
  .clk, .rst_n, .tx_disable_pin, .laser_fault_raw, .rx_light_lost_raw,
  .scl_in, .sda_out, .sda_oe, .tx_enable, .tx_fault, .rx_los, .present_gnd);
`default_nettype wire

// >>> sim/tmc_host_model.sv
// Host-side two-wire bus master for the management port.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module tmc_host_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // Bus idles released; the bus clock stands still between frames.
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Quarter of a 160 ns bit. A real host stays at or below 100 kHz; the
  // slave only needs each level to last a few core clocks, so the bench
  // runs fast to keep the run short.
  task automatic q();
    repeat (10) @(posedge clk);
  endtask

  task automatic start();
    sda_low <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sda_low <= 1'b1;
    q();
    scl <= 1'b0;
    q();
  endtask

  task automatic stop();
    sda_low <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_low <= 1'b0;
    q();
  endtask

  // Data only moves while the bus clock is low.
  task automatic clk_bit(input logic b, output logic r);
    sda_low <= !b;
    q();
    scl <= 1'b1;
    q();
    r = sda;
    q();
    scl <= 1'b0;
    q();
  endtask

  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], r);
    end
    clk_bit(1'b1, r);
    ack = !r;
  endtask

  task automatic recv(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, r);
      d[i] = r;
    end
    clk_bit(last, r);
  endtask
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench of the transceiver management block.
// Assumes the host model as bus master and a pull-up on the data wire.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int INIT = 100;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic tx_disable_pin = 1'b1;
  logic laser_fault_raw = 1'b0;
  logic rx_light_lost_raw = 1'b0;
  logic [15:0] mon_temp = 16'h1234;
  logic [15:0] mon_vcc = 16'h5678;
  logic [15:0] mon_bias = 16'h9abc;
  logic [15:0] mon_tx_power = 16'hdef0;
  logic [15:0] mon_rx_power = 16'h0fed;
  logic scl_in, sda_in, sda_low, sda_out, sda_oe;
  logic tx_enable, tx_fault, rx_los, present_gnd;
  int mismatches = 0;
  int total_checks = 0;

  // Open-drain data wire: low when either party pulls it.
  assign sda_in = !(sda_oe && !sda_out) && !sda_low;

  tmc_top #(.INIT_CYCLES(INIT)) tmc_top_i (.clk, .rst_n, .tx_disable_pin,
    .laser_fault_raw, .rx_light_lost_raw, .scl_in, .sda_in, .sda_out,
    .sda_oe, .tx_enable, .tx_fault, .rx_los, .present_gnd, .mon_temp,
    .mon_vcc, .mon_bias, .mon_tx_power, .mon_rx_power);
  tmc_host_model tmc_host_model_i (.clk, .sda(sda_in), .scl(scl_in),
    .sda_low);

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk_pin(input logic got, input logic exp, input string m);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask

  task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t page data %h not %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Enable is asked for from release on; the laser must wait for init.
  task automatic t_init();
    tx_disable_pin <= 1'b0;
    cyc(INIT - 10);
    chk_pin(tx_enable, 1'b0, "laser on in init");
    chk_pin(present_gnd, 1'b0, "presence");
    cyc(30);
    chk_pin(tx_enable, 1'b1, "laser off after init");
    chk_pin(rx_los, 1'b0, "los with light");
    $display("t_init done");
  endtask

  task automatic t_dis();
    tx_disable_pin <= 1'b1;
    cyc(4);
    chk_pin(tx_enable, 1'b0, "laser not off");
    tx_disable_pin <= 1'b0;
    cyc(4);
    chk_pin(tx_enable, 1'b1, "laser not on");
    $display("t_dis done");
  endtask

  // Disable held past the minimum so a latched fault may clear.
  task automatic pulse();
    tx_disable_pin <= 1'b1;
    cyc(2600);
    tx_disable_pin <= 1'b0;
    cyc(6);
  endtask

  task automatic t_fault();
    laser_fault_raw <= 1'b1;
    cyc(4);
    chk_pin(tx_fault, 1'b1, "fault not raised");
    pulse();
    chk_pin(tx_fault, 1'b1, "persisting fault lost");
    laser_fault_raw <= 1'b0;
    cyc(50);
    chk_pin(tx_fault, 1'b1, "fault not latched");
    tx_disable_pin <= 1'b1;
    cyc(8);
    tx_disable_pin <= 1'b0;
    cyc(8);
    chk_pin(tx_fault, 1'b1, "short pulse cleared fault");
    pulse();
    chk_pin(tx_fault, 1'b0, "fault not cleared");
    chk_pin(tx_enable, 1'b1, "laser not restored");
    $display("t_fault done");
  endtask

  task automatic t_los();
    rx_light_lost_raw <= 1'b1;
    cyc(4);
    chk_pin(rx_los, 1'b1, "los not raised");
    rx_light_lost_raw <= 1'b0;
    cyc(4);
    chk_pin(rx_los, 1'b0, "los not cleared");
    $display("t_los done");
  endtask

  // Sets the page pointer; the first byte is the device address.
  task automatic ptr(input logic [7:0] a, output logic ack);
    logic k;
    tmc_host_model_i.start();
    tmc_host_model_i.send(8'ha2, ack);
    tmc_host_model_i.send(a, k);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    logic k;
    ptr(a, k);
    tmc_host_model_i.send(v[15:8], k);
    tmc_host_model_i.send(v[7:0], k);
    tmc_host_model_i.stop();
  endtask

  task automatic rd(input logic [7:0] a, input int n,
      output logic [7:0] d [10]);
    logic k;
    ptr(a, k);
    tmc_host_model_i.start();
    tmc_host_model_i.send(8'ha3, k);
    for (int i = 0; i < n; i++) begin
      tmc_host_model_i.recv(i == n - 1, d[i]);
    end
    tmc_host_model_i.stop();
  endtask

  task automatic t_bus();
    logic a;
    logic [7:0] d [10];
    logic [15:0] mv [5];
    mv = '{mon_temp, mon_vcc, mon_bias, mon_tx_power, mon_rx_power};
    tmc_host_model_i.start();
    tmc_host_model_i.send(8'ha0, a);
    tmc_host_model_i.stop();
    chk_pin(a, 1'b0, "foreign address acked");
    ptr(8'h00, a);
    tmc_host_model_i.stop();
    chk_pin(a, 1'b1, "page address not acked");
    wr(8'h7f, 16'ha5c3);
    rd(8'h7f, 2, d);
    chk_data({d[0], d[1]}, 16'h00c3);
    wr(8'hf7, 16'h5a3c);
    rd(8'hf7, 2, d);
    chk_data({d[0], d[1]}, 16'h5a00);
    rd(8'h60, 10, d);
    for (int i = 0; i < 5; i++) begin
      chk_data({d[2 * i], d[2 * i + 1]}, mv[i]);
    end
    // Status byte with disable and light loss both raised.
    tx_disable_pin <= 1'b1;
    rx_light_lost_raw <= 1'b1;
    rd(8'h6e, 1, d);
    chk_data({8'h00, d[0]}, 16'h0082);
    tx_disable_pin <= 1'b0;
    rx_light_lost_raw <= 1'b0;
    $display("t_bus done");
  endtask

  // Clock at 250 MHz.
  initial begin
    forever #2 clk = !clk;
  end

  // Main sequence: reset for four cycles, then the scenarios.
  initial begin
    cyc(4);
    rst_n <= 1'b1;
    t_init();
    t_dis();
    t_fault();
    t_los();
    t_bus();
    conclude();
  end

  // The scenarios need about 20k cycles; this cuts a hang at 100k.
  initial begin
    #400000;
    mismatches++;
    conclude();
  end
endmodule
`default_nettype wire
